//--- bench/tb_top.sv
// self-checking bench for the two-stage event controller
`timescale 1ns/1ps
module tb_top;
	import tsec_pkg::*;
	typedef struct packed {
		logic [3:0] code;
		logic [7:0] arg;
		logic [3:0] lvl;
	} tsec_row_type;
	logic         core_clk, reset, nmi_pin, emu_pin, reset_evt_pin, wdog_expire, exc_req, hw_err;
	logic         core_timer_tick, sw_raise, evt_return, event_take_q, emu_mode_q, core_reset_q;
	logic         resume_valid_q, ret_cmd, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0]   sw_raise_level, event_level_q, resume_level_q, s_axi_wstrb, ret_dly;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  periph_irq, seq_pc, resume_addr, exp_addr, s_axi_wdata, s_axi_rdata, rdv;
	int           bad_count, checks, cyc;
	// source code, argument, expected level
	tsec_row_type rows[14] = '{16'h0000, 16'h1001, 16'h2002, 16'h3002, 16'h4003, 16'h5005, 16'h6006,
		16'h8007, 16'h8038, 16'h8059, 16'h809A, 16'h80FB, 16'h813C, 16'h81FD};
	logic [31:0]  dflt[4] = '{ASSIGN0_RST, ASSIGN1_RST, ASSIGN2_RST, ASSIGN3_RST};

	tsec_event_ctrl i_tsec_event_ctrl (.*);
	tsec_seq_model i_tsec_seq_model (.core_clk, .reset, .event_take_q, .ret_cmd, .ret_dly, .seq_pc,
		.evt_return, .exp_addr);

	// 40 MHz core clock
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("unexpected timeout: expected finish seen hang");
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bus write, both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, rdv);
	endtask
	// raise one source; pulses end in pend, held pins end at the take
	task automatic fire(input logic [3:0] c, input logic [7:0] a);
		case (c)
			4'h0: emu_pin <= 1'h1;
			4'h1: reset_evt_pin <= 1'h1;
			4'h2: nmi_pin <= 1'h1;
			4'h3: wdog_expire <= 1'h1;
			4'h4: exc_req <= 1'h1;
			4'h5: hw_err <= 1'h1;
			4'h6: core_timer_tick <= 1'h1;
			4'h7: begin
				sw_raise <= 1'h1;
				sw_raise_level <= a[3:0];
			end
			default: periph_irq[a[4:0]] <= 1'h1;
		endcase
	endtask
	task automatic pend();
		@(posedge core_clk);
		{wdog_expire, exc_req, hw_err, core_timer_tick, sw_raise} <= 5'h00;
	endtask
	task automatic take(input logic [3:0] e);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (event_take_q !== 1'h1 && n < 40);
		chk("event take", 32'h1, 32'(event_take_q));
		chk("event level", 32'(e), 32'(event_level_q));
		chk("core reset", 32'(e == LVL_RST), 32'(core_reset_q));
		chk("emu mode", 32'(e == LVL_EMU), 32'(emu_mode_q));
		{emu_pin, reset_evt_pin, nmi_pin} <= 3'h0;
		periph_irq <= 32'h0;
	endtask
	task automatic ret(input logic [3:0] e, input logic [3:0] dl);
		int n;
		n = 0;
		ret_dly <= dl;
		ret_cmd <= 1'h1;
		@(posedge core_clk);
		ret_cmd <= 1'h0;
		do begin
			@(posedge core_clk);
			n++;
		end while (resume_valid_q !== 1'h1 && n < 40);
		chk("resume valid", 32'h1, 32'(resume_valid_q));
		chk("resume level", 32'(e), 32'(resume_level_q));
		chk("resume addr", exp_addr, resume_addr);
	endtask
	task automatic serve(input tsec_row_type w, input logic [3:0] dl);
		fire(w.code, w.arg);
		pend();
		take(w.lvl);
		ret(w.lvl, dl);
	endtask

	initial begin
		reset = 1'h1;
		{nmi_pin, emu_pin, reset_evt_pin, wdog_expire, exc_req, hw_err, core_timer_tick, sw_raise} = 8'h00;
		// response readies stay high for the whole run
		{ret_cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
		{sw_raise_level, ret_dly, s_axi_awaddr, s_axi_araddr} = 24'h000000;
		{periph_irq, s_axi_wdata} = 64'h0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge core_clk);
		reset <= 1'h0;
		// reset values, read-only active bits, unmapped place
		chk("emu mode", 32'h0, 32'(emu_mode_q));
		rdchk(OFS_CMASK, 32'h0000000F);
		rdchk(OFS_PMASK, 32'h0);
		rdchk(OFS_LATCH, 32'h0);
		foreach (dflt[i])
			rdchk(OFS_ASSIGN0 + 8'(4 * i), dflt[i]);
		wr(OFS_ACTIVE, 32'h0000FFFF);
		rdchk(OFS_ACTIVE, 32'h0);
		rd(8'h40);
		chk("unmapped resp", 32'(RESP_DECERR), 32'(rsp));
		chk("unmapped data", 32'h0, rdv);
		wr(OFS_CMASK, 32'hFFFFFFFF);
		rdchk(OFS_CMASK, 32'h0000FFEF);
		wr(OFS_PMASK, 32'hFFFFFFFF);
		$display("test reset done");
		// every source kind, default routing, prompt and slow returns
		foreach (rows[i])
			serve(rows[i], 4'(i % 4 * 3));
		for (int l = 7; l < 16; l++)
			serve(tsec_row_type'({4'h7, 8'(l), 4'(l)}), 4'h1);
		$display("test rows done");
		// nesting: lower level held while a more urgent one nests
		serve(16'h6006, 4'h0);
		fire(4'h6, 8'h00);
		pend();
		take(4'h6);
		fire(4'h7, 8'h09);
		pend();
		// let an edge pass so the pulse clear and the next raise never share a time step
		@(posedge core_clk);
		fire(4'h4, 8'h00);
		pend();
		take(4'h3);
		rdchk(OFS_ACTIVE, 32'h00000048);
		rdchk(OFS_LATCH, 32'h00000200);
		ret(4'h3, 4'h0);
		ret(4'h6, 4'h5);
		take(4'h9);
		ret(4'h9, 4'h0);
		// two at once: the more urgent goes first
		fire(4'h5, 8'h00);
		fire(4'h7, 8'h0A);
		pend();
		take(4'h5);
		ret(4'h5, 4'h2);
		take(4'hA);
		ret(4'hA, 4'h0);
		$display("test nesting done");
		// masked level stays latched, software may clear it, unmask releases it
		wr(OFS_CMASK, 32'h0000F7FF);
		fire(4'h7, 8'h0B);
		pend();
		repeat (6) @(posedge core_clk);
		rdchk(OFS_LATCH, 32'h00000800);
		wr(OFS_LATCH, 32'h0);
		rdchk(OFS_LATCH, 32'h0);
		fire(4'h7, 8'h0B);
		pend();
		wr(OFS_CMASK, 32'h0000FFFF);
		rdchk(OFS_LATCH, 32'h0);
		ret(4'hB, 4'h0);
		// source 0 moved to level 12 and seen there
		wr(OFS_ASSIGN0, 32'h22211005);
		wr(OFS_CMASK, 32'h0000EFFF);
		periph_irq <= 32'h00000001;
		repeat (6) @(posedge core_clk);
		rdchk(OFS_PSTAT, 32'h00000001);
		rdchk(OFS_LATCH, 32'h00001000);
		periph_irq <= 32'h0;
		wr(OFS_CMASK, 32'h0000FFFF);
		rdchk(OFS_PSTAT, 32'h0);
		ret(4'hC, 4'h1);
		$display("test remap done");
		// mid-run reset with nothing active brings back the defaults
		reset <= 1'h1;
		repeat (2) @(posedge core_clk);
		reset <= 1'h0;
		chk("emu mode", 32'h0, 32'(emu_mode_q));
		rdchk(OFS_CMASK, 32'h0000000F);
		rdchk(OFS_ASSIGN0, ASSIGN0_RST);
		rdchk(OFS_ACTIVE, 32'h0);
		$display("test reset again done");
		test_done();
	end
endmodule

bind tsec_event_ctrl tsec_chk i_tsec_chk (.*);

//--- bench/tsec_event_ctrl_chk.sv
// port checker for the two-stage event controller
`timescale 1ns/1ps
module tsec_chk (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       evt_return,
	input wire logic       event_take_q,
	input wire logic [3:0] event_level_q,
	input wire logic       emu_mode_q,
	input wire logic       core_reset_q,
	input wire logic       resume_valid_q,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	import tsec_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// event side relations
	a_take_not_rsvd: assert property (event_take_q |-> event_level_q != LVL_RSVD)
		else $error("take on reserved level");
	a_return_blocks_take: assert property (evt_return |=> !event_take_q)
		else $error("take in a return cycle");
	a_resume_cause: assert property (resume_valid_q |-> $past(evt_return))
		else $error("resume without return");
	a_reset_pulse: assert property (core_reset_q == (event_take_q && event_level_q == LVL_RST))
		else $error("reset pulse not tied to level one take");
	a_emu_enter: assert property (event_take_q && event_level_q == LVL_EMU |-> ##[0:1] emu_mode_q)
		else $error("emulation mode not entered");
	// register bus relations
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response open");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	c_exc_take: cover property (event_take_q && event_level_q == LVL_EXC);
	c_resume: cover property (resume_valid_q);
	c_emu: cover property (emu_mode_q);
endmodule

//--- bench/tsec_seq_model.sv
// sequencer partner: moving pc, saved-address stack, return pulses
`timescale 1ns/1ps
module tsec_seq_model (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        event_take_q,
	input  wire logic        ret_cmd,
	input  wire logic [3:0]  ret_dly,
	output logic      [31:0] seq_pc,
	output logic             evt_return,
	output logic      [31:0] exp_addr
);
	logic [31:0] pc_prev_q;
	logic [3:0]  wait_q;
	logic [31:0] stk_q[$];
	// pc moves every cycle so a save in the wrong cycle shows; ret_dly picks a prompt or slow return
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			seq_pc <= 32'h00001000;
			pc_prev_q <= 32'h0;
			wait_q <= 4'h0;
			evt_return <= 1'h0;
			exp_addr <= 32'h0;
		end else begin
			seq_pc <= seq_pc + 32'h4;
			pc_prev_q <= seq_pc;
			if (event_take_q)
				stk_q.push_back(pc_prev_q);
			evt_return <= (wait_q == 4'h1);
			wait_q <= ret_cmd ? ret_dly + 4'h1 : wait_q - {3'h0, wait_q != 4'h0};
			// innermost handler leaves first, so the newest save is expected back
			if (evt_return && stk_q.size() > 0)
				exp_addr <= stk_q.pop_back();
		end
	end
endmodule

//--- verilog/tsec_event_ctrl.sv
// two-stage event controller: core priority stage, routing stage, register slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tsec_event_ctrl #(
	parameter int NSRC = 32,
	parameter int PC_W = 32
) (
	input  wire logic                core_clk,
	input  wire logic                reset,
	// event sources
	input  wire logic [NSRC-1:0]     periph_irq,
	input  wire logic                nmi_pin,
	input  wire logic                emu_pin,
	input  wire logic                reset_evt_pin,
	input  wire logic                wdog_expire,
	input  wire logic                exc_req,
	input  wire logic                hw_err,
	input  wire logic                core_timer_tick,
	input  wire logic                sw_raise,
	input  wire logic [3:0]          sw_raise_level,
	// sequencer side
	input  wire logic [PC_W-1:0]     seq_pc,
	input  wire logic                evt_return,
	output logic                     event_take_q,
	output logic [3:0]               event_level_q,
	output logic                     emu_mode_q,
	output logic                     core_reset_q,
	output logic                     resume_valid_q,
	output logic [3:0]               resume_level_q,
	output logic [PC_W-1:0]          resume_addr,
	// register slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);
	import tsec_pkg::*;

	if (NSRC < 1 || NSRC > N_SRC || PC_W < 1) begin : g_chk
		$error("tsec_event_ctrl: unsupported parameters");
	end

	localparam int NPIN = NSRC + 3;

	logic [NPIN-1:0]   pin_meta_q;
	logic [NPIN-1:0]   pin_sync_q;
	logic [2:0]        pin_prev_q;
	logic [NSRC-1:0]   pstat;
	logic              nmi_rise;
	logic              emu_rise;
	logic              rst_rise;
	logic [15:0]       latch_q;
	logic [15:0]       latch_d;
	logic [15:0]       cmask_q;
	logic [15:0]       active_q;
	logic [31:0]       pmask_q;
	logic [31:0]       assign_q [4];
	logic [NSRC*4-1:0] assign_flat;
	logic [8:0]        gp_req;
	logic [15:0]       eff_mask;
	logic [15:0]       pending;
	logic [15:0]       hw_set;
	logic [15:0]       take_hot;
	logic              cand_ok;
	logic [3:0]        cand_lvl;
	logic              act_any;
	logic [3:0]        act_lvl;
	logic              take;
	logic              ret;
	logic [7:0]        awaddr_q;
	logic              aw_full_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              w_full_q;
	logic              wr_fire;
	logic [3:0]        wr_idx;

	// lowest set bit wins, since lower index is more urgent
	function automatic logic [4:0] first_set(input logic [15:0] v);
		logic [4:0] r;
		r = {1'b0, 4'hF};
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// byte offset to register index, shared by read and write paths
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		case (a)
			OFS_LATCH:   return IDX_LATCH;
			OFS_CMASK:   return IDX_CMASK;
			OFS_ACTIVE:  return IDX_ACTIVE;
			OFS_PMASK:   return IDX_PMASK;
			OFS_PSTAT:   return IDX_PSTAT;
			OFS_ASSIGN0: return IDX_ASSIGN0;
			OFS_ASSIGN1: return IDX_ASSIGN0 + 4'h1;
			OFS_ASSIGN2: return IDX_ASSIGN0 + 4'h2;
			OFS_ASSIGN3: return IDX_ASSIGN0 + 4'h3;
			default:     return IDX_NONE;
		endcase
	endfunction

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// two-stage synchroniser for periph_irq and the three event pins; only the second stage is read
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			pin_prev_q <= '0;
		end else begin
			pin_meta_q <= {reset_evt_pin, emu_pin, nmi_pin, periph_irq};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q[NPIN-1 -: 3];
		end
	end

	assign pstat    = pin_sync_q[NSRC-1:0];
	assign nmi_rise = pin_sync_q[NSRC] & ~pin_prev_q[0];
	assign emu_rise = pin_sync_q[NSRC+1] & ~pin_prev_q[1];
	assign rst_rise = pin_sync_q[NSRC+2] & ~pin_prev_q[2];

	always_comb begin
		for (int s = 0; s < NSRC; s++) begin
			assign_flat[s*4 +: 4] = assign_q[s / FLD_PER_REG][(s % FLD_PER_REG)*FLD_W +: FLD_W];
		end
	end

	tsec_route #(
		.NSRC (NSRC)
	) u_route (
		.core_clk    (core_clk),
		.reset       (reset),
		.periph_stat (pstat),
		.periph_mask (pmask_q[NSRC-1:0]),
		.assign_map  (assign_flat),
		.gp_req_q    (gp_req)
	);

	// levels 0-3 cannot be masked, level 4 does not exist
	assign eff_mask = (cmask_q | CMASK_FIXED) & LATCH_VALID;
	assign pending  = latch_q & eff_mask;
	assign {cand_ok, cand_lvl} = first_set(pending);
	assign {act_any, act_lvl}  = first_set(active_q);

	// return has the cycle to itself; a take waits one cycle behind it
	assign ret  = evt_return && act_any;
	assign take = cand_ok && (!act_any || cand_lvl < act_lvl) && !evt_return;
	assign take_hot = take ? (16'h0001 << cand_lvl) : 16'h0000;

	// event sources that set latch bits
	always_comb begin
		hw_set             = '0;
		hw_set[LVL_EMU]    = emu_rise;
		hw_set[LVL_RST]    = rst_rise;
		hw_set[LVL_NMI]    = nmi_rise | wdog_expire;
		hw_set[LVL_EXC]    = exc_req;
		hw_set[LVL_HWE]    = hw_err;
		hw_set[LVL_TMR]    = core_timer_tick;
		// the active bit acts as the acknowledge that stops relatching
		hw_set[15:7]       = gp_req & ~active_q[15:7] & ~take_hot[15:7];
		if (sw_raise && sw_raise_level >= LVL_GP_LO) begin
			hw_set[sw_raise_level] = 1'b1;
		end
	end

	// latch next value: software writes only masked-off bits; hardware set beats any clear
	always_comb begin
		latch_d = latch_q;
		if (wr_fire && wr_idx == IDX_LATCH) begin
			latch_d = (latch_q & eff_mask) | (16'(merge(32'(latch_q), wdata_q, wstrb_q)) & ~eff_mask);
		end
		latch_d = ((latch_d & ~take_hot) | hw_set) & LATCH_VALID;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// active bits: set on acceptance, cleared on return; a reset-level take clears all the others
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			active_q <= '0;
		end else if (take && cand_lvl == LVL_RST) begin
			active_q <= take_hot;
		end else if (take) begin
			active_q <= active_q | take_hot;
		end else if (ret) begin
			active_q <= active_q & ~(16'h0001 << act_lvl);
		end
	end

	// sequencer strobes; a take of the reset level also pulses core_reset_q
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			event_take_q   <= 1'b0;
			event_level_q  <= '0;
			core_reset_q   <= 1'b0;
			resume_valid_q <= 1'b0;
			resume_level_q <= '0;
		end else begin
			event_take_q   <= take;
			core_reset_q   <= take && cand_lvl == LVL_RST;
			resume_valid_q <= ret;
			if (take) begin
				event_level_q <= cand_lvl;
			end
			if (ret) begin
				resume_level_q <= act_lvl;
			end
		end
	end

	// emulation mode lasts from emulation entry to its return or to a take of the reset level
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			emu_mode_q <= 1'b0;
		end else if (take && cand_lvl == LVL_EMU) begin
			emu_mode_q <= 1'b1;
		end else if ((ret && act_lvl == LVL_EMU) || (take && cand_lvl == LVL_RST)) begin
			emu_mode_q <= 1'b0;
		end
	end

	// interrupted address saved per level, replayed on return
	tsec_ret_mem #(
		.DEPTH (N_LVL),
		.WIDTH (PC_W)
	) u_ret (
		.core_clk  (core_clk),
		.wr_en     (take),
		.wr_addr   (cand_lvl),
		.wr_data   (seq_pc),
		.rd_addr   (act_lvl),
		.rd_data_q (resume_addr)
	);

	// write channel: address and data accepted in either order
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_idx  = reg_index(awaddr_q);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			awaddr_q      <= '0;
			aw_full_q     <= 1'b0;
			s_axi_awready <= 1'b1;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			w_full_q      <= 1'b0;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == IDX_NONE) ? RESP_DECERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// software-owned control registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cmask_q     <= CMASK_RST;
			pmask_q     <= PMASK_RST;
			assign_q[0] <= ASSIGN0_RST;
			assign_q[1] <= ASSIGN1_RST;
			assign_q[2] <= ASSIGN2_RST;
			assign_q[3] <= ASSIGN3_RST;
		end else if (wr_fire) begin
			case (wr_idx)
				IDX_CMASK:          cmask_q <= 16'(merge(32'(cmask_q), wdata_q, wstrb_q)) & CMASK_WRITABLE;
				IDX_PMASK:          pmask_q <= merge(pmask_q, wdata_q, wstrb_q);
				IDX_ASSIGN0:        assign_q[0] <= merge(assign_q[0], wdata_q, wstrb_q);
				IDX_ASSIGN0 + 4'h1: assign_q[1] <= merge(assign_q[1], wdata_q, wstrb_q);
				IDX_ASSIGN0 + 4'h2: assign_q[2] <= merge(assign_q[2], wdata_q, wstrb_q);
				IDX_ASSIGN0 + 4'h3: assign_q[3] <= merge(assign_q[3], wdata_q, wstrb_q);
				default:            cmask_q <= cmask_q;
			endcase
		end
	end

	// read channel: data registered at the address handshake
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (reg_index(s_axi_araddr))
				IDX_LATCH:          s_axi_rdata <= {16'h0000, latch_q};
				IDX_CMASK:          s_axi_rdata <= {16'h0000, eff_mask};
				IDX_ACTIVE:         s_axi_rdata <= {16'h0000, active_q};
				IDX_PMASK:          s_axi_rdata <= pmask_q;
				IDX_PSTAT:          s_axi_rdata <= 32'(pstat);
				IDX_ASSIGN0:        s_axi_rdata <= assign_q[0];
				IDX_ASSIGN0 + 4'h1: s_axi_rdata <= assign_q[1];
				IDX_ASSIGN0 + 4'h2: s_axi_rdata <= assign_q[2];
				IDX_ASSIGN0 + 4'h3: s_axi_rdata <= assign_q[3];
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

//--- verilog/tsec_pkg.sv
// constants shared by the two-stage event controller
package tsec_pkg;

	// core level numbering, 0 is the most urgent
	localparam int         N_LVL      = 16;
	localparam int         N_GP       = 9;
	localparam int         N_SRC      = 32;
	localparam int         FLD_W      = 4;
	localparam int         FLD_PER_REG = 8;
	localparam logic [3:0] LVL_EMU    = 4'h0;
	localparam logic [3:0] LVL_RST    = 4'h1;
	localparam logic [3:0] LVL_NMI    = 4'h2;
	localparam logic [3:0] LVL_EXC    = 4'h3;
	localparam logic [3:0] LVL_RSVD   = 4'h4;
	localparam logic [3:0] LVL_HWE    = 4'h5;
	localparam logic [3:0] LVL_TMR    = 4'h6;
	localparam logic [3:0] LVL_GP_LO  = 4'h7;

	// register byte offsets
	localparam logic [7:0] OFS_LATCH   = 8'h00;
	localparam logic [7:0] OFS_CMASK   = 8'h04;
	localparam logic [7:0] OFS_ACTIVE  = 8'h08;
	localparam logic [7:0] OFS_PMASK   = 8'h0C;
	localparam logic [7:0] OFS_PSTAT   = 8'h10;
	localparam logic [7:0] OFS_ASSIGN0 = 8'h14;
	localparam logic [7:0] OFS_ASSIGN1 = 8'h18;
	localparam logic [7:0] OFS_ASSIGN2 = 8'h1C;
	localparam logic [7:0] OFS_ASSIGN3 = 8'h20;

	// register indices returned by the address decoder
	localparam logic [3:0] IDX_LATCH   = 4'h0;
	localparam logic [3:0] IDX_CMASK   = 4'h1;
	localparam logic [3:0] IDX_ACTIVE  = 4'h2;
	localparam logic [3:0] IDX_PMASK   = 4'h3;
	localparam logic [3:0] IDX_PSTAT   = 4'h4;
	localparam logic [3:0] IDX_ASSIGN0 = 4'h5;
	localparam logic [3:0] IDX_NONE    = 4'hF;

	// reset values and fixed bits
	localparam logic [15:0] CMASK_RST      = 16'h0000;
	localparam logic [15:0] CMASK_FIXED    = 16'h000F;
	localparam logic [15:0] CMASK_WRITABLE = 16'hFFE0;
	localparam logic [15:0] LATCH_VALID    = 16'hFFEF;
	localparam logic [31:0] PMASK_RST      = 32'h00000000;
	localparam logic [31:0] ASSIGN0_RST    = 32'h22211000;
	localparam logic [31:0] ASSIGN1_RST    = 32'h43333332;
	localparam logic [31:0] ASSIGN2_RST    = 32'h55555444;
	localparam logic [31:0] ASSIGN3_RST    = 32'h66655555;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

//--- verilog/tsec_ret_mem.sv
// return address store, one word per core level
`timescale 1ns/1ps
module tsec_ret_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 32
) (
	input  wire logic                     core_clk,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data_q
);
	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("tsec_ret_mem: unsupported geometry");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// write and registered read; a same-cycle clash returns the old word
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule

//--- verilog/tsec_route.sv
// system routing stage: peripheral requests to general-purpose levels
`timescale 1ns/1ps
module tsec_route #(
	parameter int NSRC = 32
) (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic [NSRC-1:0]       periph_stat,
	input  wire logic [NSRC-1:0]       periph_mask,
	input  wire logic [NSRC*4-1:0]     assign_map,
	output logic      [8:0]            gp_req_q
);
	import tsec_pkg::*;

	if (NSRC < 1 || NSRC > N_SRC) begin : g_chk
		$error("tsec_route: unsupported source count");
	end

	logic [8:0] gp_req_d;

	// or every unmasked source into the level its field selects
	always_comb begin
		gp_req_d = '0;
		for (int s = 0; s < NSRC; s++) begin
			if (periph_stat[s] && periph_mask[s] && assign_map[s*4 +: 4] < 4'(N_GP)) begin
				gp_req_d[assign_map[s*4 +: 4]] = 1'b1;
			end
		end
	end

	// registered so the level lines are glitch free
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			gp_req_q <= '0;
		end else begin
			gp_req_q <= gp_req_d;
		end
	end
endmodule
